// *** gpm_pkg.sv ***
// constants and types shared by the power mode control block
// Contract
// - pack removal sleeps and releases status output
// - sleep entry completes within 1 ms
// - bus activity wakes device within 300 us
// - integrate sense polarity into charge/discharge counts
// - offset measured and removed without host action
// - 224 flash, 8 ID, 32 RAM bytes reachable
// - several devices share one bus line
// - backup pin holds state, drives supply when valid
package gpm_pkg;
	localparam int CLK_PERIOD_NS = 25;
	localparam int CLK_PER_US = 1000 / CLK_PERIOD_NS;
	localparam int US_PER_MS = 1000;

	// longest times, rounded down to whole cycles
	localparam int SLEEP_MAX_MS = 1;
	localparam int SLEEP_MAX_CYC = SLEEP_MAX_MS * 1000000 / CLK_PERIOD_NS;
	localparam int WAKE_MAX_US = 300;
	localparam int WAKE_MAX_CYC = WAKE_MAX_US * 1000 / CLK_PERIOD_NS;
	localparam int PWRUP_MAX_MS = 500;
	localparam int PWRUP_MAX_CYC = PWRUP_MAX_MS * 1000000 / CLK_PERIOD_NS;
	localparam int WAIT_W = 25;

	// offset calibration schedule in millisecond ticks
	localparam int CAL_PERIOD_MIN = 60;
	localparam int CAL_PERIOD_MS = CAL_PERIOD_MIN * 60 * US_PER_MS;
	localparam int CAL_LEN_MS = 10;
	localparam int CAL_W = 22;

	// counting widths
	localparam int COUNT_W = 32;
	localparam int OFFS_W = 16;

	// memory map, byte addresses
	localparam int ADDR_W = 9;
	localparam int FLASH_BYTES = 224;
	localparam int ID_BYTES = 8;
	localparam int RAM_BYTES = 32;
	localparam logic [8:0] FLASH_BASE = 9'h000;
	localparam logic [8:0] ID_BASE = 9'h0E0;
	localparam logic [8:0] RAM_BASE = 9'h0E8;
	localparam logic [8:0] MEM_END = 9'h108;
	// arbitrary identification value
	localparam logic [63:0] ID_CODE = 64'h0123456789ABCDEF;

	// reset values
	localparam logic [7:0] RDATA_RST = 8'h00;
	localparam logic [COUNT_W-1:0] COUNT_RST = 32'h00000000;
	localparam logic [OFFS_W-1:0] OFFS_RST = 16'h0000;

	typedef enum logic [2:0] {ST_POWERUP, ST_ACTIVE, ST_SLEEP_PEND, ST_SLEEP, ST_WAKING} gpm_state_t;
	typedef enum logic [1:0] {RG_FLASH, RG_ID, RG_RAM, RG_NONE} gpm_region_t;
endpackage

// *** gpm_time_if.sv ***
// timebase signals passed from the divider to the control logic
`timescale 1ns/1ps
interface gpm_time_if;
	logic tick_ms;
	logic cal_active;
	logic cal_end;
	modport src (output tick_ms, output cal_active, output cal_end);
	modport dst (input tick_ms, input cal_active, input cal_end);
endinterface

// *** gpm_timebase.sv ***
// internal timebase: millisecond tick and periodic offset calibration window
`timescale 1ns/1ps
module gpm_timebase
#(
	parameter logic [21:0] CAL_PERIOD_MS = 22'(gpm_pkg::CAL_PERIOD_MS),
	parameter logic [21:0] CAL_LEN_MS = 22'(gpm_pkg::CAL_LEN_MS)
)
(
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// timing outputs
	gpm_time_if.src tb
);
	localparam logic [5:0] US_LAST = 6'(gpm_pkg::CLK_PER_US - 1);
	localparam logic [9:0] MS_LAST = 10'(gpm_pkg::US_PER_MS - 1);
	logic [5:0] us_div;
	logic [9:0] ms_div;
	logic [21:0] cal_cnt;
	logic tick_ms;
	logic cal_end;
	logic us_tick;

	assign us_tick = (us_div == US_LAST);

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			us_div <= 6'h00;
		else if (us_tick)
			us_div <= 6'h00;
		else
			us_div <= us_div + 6'h01;
	end

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			ms_div <= 10'h000;
			tick_ms <= 1'b0;
		end
		else
		begin
			tick_ms <= us_tick && (ms_div == MS_LAST);
			if (us_tick)
				ms_div <= (ms_div == MS_LAST) ? 10'h000 : ms_div + 10'h001;
		end
	end

	// window end is flagged on the same edge that closes the window
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			cal_cnt <= 22'h000000;
			cal_end <= 1'b0;
		end
		else
		begin
			cal_end <= tick_ms && (cal_cnt == CAL_LEN_MS - 22'h000001);
			if (tick_ms)
				cal_cnt <= (cal_cnt == CAL_PERIOD_MS - 22'h000001) ? 22'h000000 : cal_cnt + 22'h000001;
		end
	end

	assign tb.tick_ms = tick_ms;
	assign tb.cal_active = (cal_cnt < CAL_LEN_MS);
	assign tb.cal_end = cal_end;
endmodule

// *** gpm_top.sv ***
// power mode control, charge counting and memory of the charge monitor
`timescale 1ns/1ps
module gpm_top
#(
	parameter int PWRUP_CYC = gpm_pkg::PWRUP_MAX_CYC,
	parameter int SLEEP_CYC = gpm_pkg::SLEEP_MAX_CYC,
	parameter int WAKE_CYC = gpm_pkg::WAKE_MAX_CYC,
	parameter logic [21:0] CAL_PERIOD_MS = 22'(gpm_pkg::CAL_PERIOD_MS),
	parameter logic [21:0] CAL_LEN_MS = 22'(gpm_pkg::CAL_LEN_MS),
	parameter logic [63:0] ID_CODE = gpm_pkg::ID_CODE
)
(
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// pack detect and supply monitor
	input wire logic pack_present_in,
	input wire logic supply_valid_in,
	// backup supply pin
	input wire logic backup_supply_pin_in,
	output logic backup_supply_pin_out,
	output logic backup_supply_pin_oe_n_out,
	// single-wire bus line
	input wire logic bus_line_in,
	input wire logic bus_pull_req_in,
	output logic bus_line_out,
	output logic bus_line_oe_n_out,
	// open-drain status output
	input wire logic stat_drive_in,
	output logic stat_out,
	output logic stat_oe_n_out,
	// charge rate converter
	input wire logic conv_pulse_in,
	input wire logic conv_polarity_in,
	output logic cal_active_out,
	output logic [31:0] charge_count_out,
	output logic [31:0] discharge_count_out,
	output logic [15:0] offset_count_out,
	// memory access port
	input wire logic mem_rd_in,
	input wire logic mem_wr_in,
	input wire logic [8:0] mem_addr_in,
	input wire logic [7:0] mem_wdata_in,
	output logic [7:0] mem_rdata_out,
	// mode status
	output logic ready_out,
	output logic asleep_out
);
	localparam logic [24:0] PWRUP_LAST = 25'(PWRUP_CYC - 1);
	localparam logic [24:0] SLEEP_LAST = 25'(SLEEP_CYC - 1);
	localparam logic [24:0] WAKE_LAST = 25'(WAKE_CYC - 1);

	gpm_pkg::gpm_state_t state;
	gpm_pkg::gpm_state_t next_state;
	logic [24:0] wait_cnt;
	logic pack_prev;
	logic bus_prev;
	logic sleep_req;
	logic pack_fall;
	logic bus_fall;
	logic mem_busy;
	logic access_ok;
	logic [31:0] charge;
	logic [31:0] discharge;
	logic [15:0] offset;
	logic [31:0] next_charge;
	logic [31:0] next_discharge;
	logic [15:0] next_offset;
	logic [31:0] off_mag;
	logic [7:0] flash_mem [gpm_pkg::FLASH_BYTES];
	logic [7:0] ram_mem [gpm_pkg::RAM_BYTES];
	gpm_pkg::gpm_region_t rg;

	gpm_time_if tbi ();

	gpm_timebase #(
		.CAL_PERIOD_MS(CAL_PERIOD_MS),
		.CAL_LEN_MS(CAL_LEN_MS)
	) u_timebase (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.tb(tbi.src)
	);

	function automatic gpm_pkg::gpm_region_t region(input logic [8:0] a);
		if (a < gpm_pkg::ID_BASE)
			region = gpm_pkg::RG_FLASH;
		else if (a < gpm_pkg::RAM_BASE)
			region = gpm_pkg::RG_ID;
		else if (a < gpm_pkg::MEM_END)
			region = gpm_pkg::RG_RAM;
		else
			region = gpm_pkg::RG_NONE;
	endfunction

	assign pack_fall = pack_prev && !pack_present_in;
	assign bus_fall = bus_prev && !bus_line_in;
	assign mem_busy = mem_rd_in || mem_wr_in;
	assign access_ok = (state == gpm_pkg::ST_ACTIVE) || (state == gpm_pkg::ST_SLEEP_PEND);
	assign rg = region(mem_addr_in);

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			pack_prev <= 1'b0;
			bus_prev <= 1'b1;
		end
		else
		begin
			pack_prev <= pack_present_in;
			bus_prev <= bus_line_in;
		end
	end

	// a pack removal is remembered until sleep entry takes it, so a wake never re-sleeps on a stale fall
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			sleep_req <= 1'b0;
		else if (state == gpm_pkg::ST_ACTIVE && next_state == gpm_pkg::ST_SLEEP_PEND)
			sleep_req <= 1'b0;
		else if (pack_fall)
			sleep_req <= 1'b1;
	end

	always_comb
	begin
		next_state = state;
		case (state)
			gpm_pkg::ST_POWERUP:
				if (wait_cnt == PWRUP_LAST)
					next_state = gpm_pkg::ST_ACTIVE;
			gpm_pkg::ST_ACTIVE:
				if (sleep_req || pack_fall)
					next_state = gpm_pkg::ST_SLEEP_PEND;
			gpm_pkg::ST_SLEEP_PEND:
				if (!mem_busy || wait_cnt == SLEEP_LAST)
					next_state = gpm_pkg::ST_SLEEP;
			gpm_pkg::ST_SLEEP:
				if (bus_fall)
					next_state = gpm_pkg::ST_WAKING;
			gpm_pkg::ST_WAKING:
				if (wait_cnt == WAKE_LAST)
					next_state = gpm_pkg::ST_ACTIVE;
			default:
				next_state = gpm_pkg::ST_POWERUP;
		endcase
	end

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			state <= gpm_pkg::ST_POWERUP;
			wait_cnt <= 25'h0000000;
		end
		else
		begin
			state <= next_state;
			wait_cnt <= (next_state != state) ? 25'h0000000 : wait_cnt + 25'h0000001;
		end
	end

	// mode outputs and pins, all registered
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			ready_out <= 1'b0;
			asleep_out <= 1'b0;
			stat_out <= 1'b0;
			stat_oe_n_out <= 1'b1;
			bus_line_out <= 1'b0;
			bus_line_oe_n_out <= 1'b1;
			backup_supply_pin_out <= 1'b0;
			backup_supply_pin_oe_n_out <= 1'b1;
			cal_active_out <= 1'b0;
		end
		else
		begin
			ready_out <= (next_state == gpm_pkg::ST_ACTIVE) || (next_state == gpm_pkg::ST_SLEEP_PEND);
			asleep_out <= (next_state == gpm_pkg::ST_SLEEP);
			stat_out <= 1'b0;
			stat_oe_n_out <= !(stat_drive_in && next_state == gpm_pkg::ST_ACTIVE);
			bus_line_out <= 1'b0;
			bus_line_oe_n_out <= !(bus_pull_req_in
				&& (next_state == gpm_pkg::ST_ACTIVE || next_state == gpm_pkg::ST_SLEEP_PEND));
			backup_supply_pin_out <= 1'b1;
			backup_supply_pin_oe_n_out <= !supply_valid_in;
			cal_active_out <= tbi.cal_active;
		end
	end

	// counting: converter pulses go to charge, discharge or the offset estimate
	always_comb
	begin
		next_charge = charge;
		next_discharge = discharge;
		next_offset = offset;
		off_mag = offset[15] ? {16'h0000, 16'(-offset)} : {16'h0000, offset};
		if (tbi.cal_end)
		begin
			if (!offset[15])
				next_charge = (charge > off_mag) ? charge - off_mag : gpm_pkg::COUNT_RST;
			else
				next_discharge = (discharge > off_mag) ? discharge - off_mag : gpm_pkg::COUNT_RST;
			next_offset = gpm_pkg::OFFS_RST;
		end
		if (conv_pulse_in)
		begin
			if (tbi.cal_active)
				next_offset = conv_polarity_in ? offset + 16'h0001 : offset - 16'h0001;
			else if (conv_polarity_in)
				next_charge = next_charge + 32'h00000001;
			else
				next_discharge = next_discharge + 32'h00000001;
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			charge <= gpm_pkg::COUNT_RST;
			discharge <= gpm_pkg::COUNT_RST;
			offset <= gpm_pkg::OFFS_RST;
		end
		else
		begin
			charge <= next_charge;
			discharge <= next_discharge;
			offset <= next_offset;
		end
	end

	assign charge_count_out = charge;
	assign discharge_count_out = discharge;
	assign offset_count_out = offset;

	// memory contents are held, not reset: flash is nonvolatile, ram rides on backup
	always_ff @(posedge clk_in)
	begin
		if (mem_wr_in && access_ok && rg == gpm_pkg::RG_FLASH)
			flash_mem[8'(mem_addr_in - gpm_pkg::FLASH_BASE)] <= mem_wdata_in;
		if (mem_wr_in && access_ok && rg == gpm_pkg::RG_RAM)
			ram_mem[5'(mem_addr_in - gpm_pkg::RAM_BASE)] <= mem_wdata_in;
	end

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
			mem_rdata_out <= gpm_pkg::RDATA_RST;
		else if (mem_rd_in && access_ok)
		begin
			case (rg)
				gpm_pkg::RG_FLASH:
					mem_rdata_out <= flash_mem[8'(mem_addr_in - gpm_pkg::FLASH_BASE)];
				gpm_pkg::RG_ID:
					mem_rdata_out <= ID_CODE[8*3'(mem_addr_in - gpm_pkg::ID_BASE) +: 8];
				gpm_pkg::RG_RAM:
					mem_rdata_out <= ram_mem[5'(mem_addr_in - gpm_pkg::RAM_BASE)];
				default:
					mem_rdata_out <= gpm_pkg::RDATA_RST;
			endcase
		end
	end

	// checks
	logic [24:0] chk_cnt;
	always_ff @(posedge clk_in)
	begin
		if (rst_in || (state != gpm_pkg::ST_SLEEP_PEND && state != gpm_pkg::ST_WAKING))
			chk_cnt <= 25'h0000000;
		else
			chk_cnt <= chk_cnt + 25'h0000001;
	end

	property p_stat_released;
		@(posedge clk_in) disable iff (rst_in) (state == gpm_pkg::ST_SLEEP) |-> stat_oe_n_out;
	endproperty
	a_stat_released: assert property (p_stat_released) else $error("status pin pulled during sleep");

	property p_sleep_entered;
		@(posedge clk_in) disable iff (rst_in)
		(state == gpm_pkg::ST_ACTIVE && pack_fall) |=> (state == gpm_pkg::ST_SLEEP_PEND);
	endproperty
	a_sleep_entered: assert property (p_sleep_entered) else $error("pack removal did not start sleep");

	property p_sleep_bound;
		@(posedge clk_in) disable iff (rst_in) (state == gpm_pkg::ST_SLEEP_PEND) |-> (chk_cnt < 25'(SLEEP_CYC));
	endproperty
	a_sleep_bound: assert property (p_sleep_bound) else $error("sleep entry too slow");

	property p_wake_bound;
		@(posedge clk_in) disable iff (rst_in) (state == gpm_pkg::ST_WAKING) |-> (chk_cnt < 25'(WAKE_CYC));
	endproperty
	a_wake_bound: assert property (p_wake_bound) else $error("wake-up too slow");

	property p_wake_start;
		@(posedge clk_in) disable iff (rst_in)
		(state == gpm_pkg::ST_SLEEP && bus_fall) |=> (state == gpm_pkg::ST_WAKING) ##1 !ready_out;
	endproperty
	a_wake_start: assert property (p_wake_start) else $error("bus edge did not wake");

	property p_charge_count;
		@(posedge clk_in) disable iff (rst_in)
		(conv_pulse_in && conv_polarity_in && !tbi.cal_active && !tbi.cal_end) |=> (charge == $past(charge) + 32'h00000001);
	endproperty
	a_charge_count: assert property (p_charge_count) else $error("charge pulse not counted");

	property p_discharge_count;
		@(posedge clk_in) disable iff (rst_in)
		(conv_pulse_in && !conv_polarity_in && !tbi.cal_active && !tbi.cal_end)
		|=> (discharge == $past(discharge) + 32'h00000001) && (charge == $past(charge));
	endproperty
	a_discharge_count: assert property (p_discharge_count) else $error("discharge pulse not counted");

	property p_offset_track;
		@(posedge clk_in) disable iff (rst_in)
		(conv_pulse_in && tbi.cal_active) |=> (charge == $past(charge)) && (offset != $past(offset));
	endproperty
	a_offset_track: assert property (p_offset_track) else $error("offset pulse misrouted");

	property p_id_read;
		@(posedge clk_in) disable iff (rst_in)
		(mem_rd_in && access_ok && mem_addr_in == gpm_pkg::ID_BASE) |=> (mem_rdata_out == ID_CODE[7:0]);
	endproperty
	a_id_read: assert property (p_id_read) else $error("id byte wrong");

	property p_bus_pull_only;
		@(posedge clk_in) disable iff (rst_in) !bus_line_out && (!asleep_out || bus_line_oe_n_out);
	endproperty
	a_bus_pull_only: assert property (p_bus_pull_only) else $error("bus line driven high or in sleep");

	property p_backup_pin;
		@(posedge clk_in) disable iff (rst_in) 1'b1 |=> (backup_supply_pin_oe_n_out == !$past(supply_valid_in));
	endproperty
	a_backup_pin: assert property (p_backup_pin) else $error("backup pin direction wrong");

	c_sleep: cover property (@(posedge clk_in) disable iff (rst_in) state == gpm_pkg::ST_SLEEP);
	c_wake: cover property (@(posedge clk_in) disable iff (rst_in) state == gpm_pkg::ST_WAKING ##1 state == gpm_pkg::ST_ACTIVE);
	c_cal_end: cover property (@(posedge clk_in) disable iff (rst_in) tbi.cal_end && offset != gpm_pkg::OFFS_RST);
endmodule

// *** gpm_host_model.sv ***
// host controller model on the shared single-wire bus line
`timescale 1ns/1ps
module gpm_host_model
#(
	parameter int HOLD_CYC = 51,
	parameter int LOW_CYC = 8
)
(
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// requests from the bench
	input wire logic wake_req_in,
	input wire logic other_pull_in,
	// device open-drain pin
	input wire logic dev_oe_n_in,
	// resolved line
	output logic bus_out
);
	int since_rst;
	int low_left;
	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			since_rst <= 0;
			low_left <= 0;
		end
		else
		begin
			if (since_rst < HOLD_CYC)
				since_rst <= since_rst + 1;
			// no traffic until the device has had its settling time
			if (wake_req_in && since_rst >= HOLD_CYC && low_left == 0)
				low_left <= LOW_CYC;
			else if (low_left != 0)
				low_left <= low_left - 1;
		end
	end
	// pulled-up line shared with other devices: any party pulling low wins
	assign bus_out = !((low_left != 0) || other_pull_in || !dev_oe_n_in);
endmodule

// *** test_gpm_top.sv ***
// self-checking bench for the power mode control block
`timescale 1ns/1ps
module test_gpm_top;
	localparam int PWRUP = 50;
	localparam int SLP = 20;
	localparam int WAKE = 20;
	logic clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic pack_present_in = 1'b1;
	logic supply_valid_in = 1'b1;
	logic bus_pull_req_in = 1'b0;
	logic stat_drive_in = 1'b0;
	logic conv_pulse_in = 1'b0;
	logic conv_polarity_in = 1'b0;
	logic mem_rd_in = 1'b0;
	logic mem_wr_in = 1'b0;
	logic [8:0] mem_addr_in = 9'h000;
	logic [7:0] mem_wdata_in = 8'h00;
	logic wake_req = 1'b0;
	logic other_pull = 1'b0;
	logic bus_line;
	logic backup_supply_pin_out;
	logic backup_supply_pin_oe_n_out;
	logic bus_line_out;
	logic bus_line_oe_n_out;
	logic stat_out;
	logic stat_oe_n_out;
	logic cal_active_out;
	logic [31:0] charge_count_out;
	logic [31:0] discharge_count_out;
	logic [15:0] offset_count_out;
	logic [7:0] mem_rdata_out;
	logic ready_out;
	logic asleep_out;
	int errors = 0;
	int cmp_count = 0;
	int seed = 76;
	int n;
	int i;
	int np;
	int nn;
	logic [7:0] rd_q [$];
	logic rd_d1 = 1'b0;
	logic [8:0] adr [4] = '{9'h000, 9'h0DF, 9'h0E8, 9'h107};
	logic [7:0] wd [4];

	always #12.5 clk_in = ~clk_in;

	gpm_top #(.PWRUP_CYC(PWRUP), .SLEEP_CYC(SLP), .WAKE_CYC(WAKE), .CAL_PERIOD_MS(22'h000014),
		.CAL_LEN_MS(22'h000001)) u_gpm_top (
		.clk_in(clk_in), .rst_in(rst_in), .pack_present_in(pack_present_in), .supply_valid_in(supply_valid_in),
		.backup_supply_pin_in(1'b1), .backup_supply_pin_out(backup_supply_pin_out),
		.backup_supply_pin_oe_n_out(backup_supply_pin_oe_n_out), .bus_line_in(bus_line),
		.bus_pull_req_in(bus_pull_req_in), .bus_line_out(bus_line_out), .bus_line_oe_n_out(bus_line_oe_n_out),
		.stat_drive_in(stat_drive_in), .stat_out(stat_out), .stat_oe_n_out(stat_oe_n_out),
		.conv_pulse_in(conv_pulse_in), .conv_polarity_in(conv_polarity_in), .cal_active_out(cal_active_out),
		.charge_count_out(charge_count_out), .discharge_count_out(discharge_count_out),
		.offset_count_out(offset_count_out), .mem_rd_in(mem_rd_in), .mem_wr_in(mem_wr_in),
		.mem_addr_in(mem_addr_in), .mem_wdata_in(mem_wdata_in), .mem_rdata_out(mem_rdata_out),
		.ready_out(ready_out), .asleep_out(asleep_out));

	gpm_host_model #(.HOLD_CYC(PWRUP + 1), .LOW_CYC(8)) u_gpm_host_model (
		.clk_in(clk_in), .rst_in(rst_in), .wake_req_in(wake_req), .other_pull_in(other_pull),
		.dev_oe_n_in(bus_line_oe_n_out), .bus_out(bus_line));

	task automatic summarize();
		if (errors == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one memory cycle per edge; a read notes its expected byte
	task automatic acc(input logic wr, input logic rd, input logic [8:0] a, input logic [7:0] d);
		@(posedge clk_in);
		mem_wr_in <= wr;
		mem_rd_in <= rd;
		mem_addr_in <= a;
		mem_wdata_in <= d;
		if (rd)
			rd_q.push_back(d);
	endtask

	// which 0 waits for ready, 1 for asleep, 2 for the end of the calibration window
	function automatic logic seen(input int which);
		if (which == 0)
			return ready_out;
		else if (which == 1)
			return asleep_out;
		else
			return !cal_active_out;
	endfunction

	task automatic wait_hi(input int which, input int lim);
		n = 0;
		while (n < lim && seen(which) !== 1'b1)
		begin
			@(posedge clk_in);
			n++;
		end
		if (seen(which) !== 1'b1)
		begin
			errors++;
			summarize();
		end
	endtask

	// one converter pulse per cycle: p with polarity high, then q with polarity low
	task automatic pulses(input int p, input int q);
		for (int k = 0; k < p + q; k++)
		begin
			@(posedge clk_in);
			conv_pulse_in <= 1'b1;
			conv_polarity_in <= (k < p);
		end
		@(posedge clk_in);
		conv_pulse_in <= 1'b0;
		repeat (2) @(posedge clk_in);
	endtask

	// read data lands one edge after the strobe is taken
	always @(posedge clk_in)
	begin
		rd_d1 <= mem_rd_in;
		if (rd_d1)
			chk(32'(mem_rdata_out), 32'(rd_q.pop_front()));
	end

	initial
	begin
		repeat (6) @(posedge clk_in);
		rst_in <= 1'b0;
		@(posedge clk_in);
		chk(stat_oe_n_out, 1'b1);
		chk(ready_out, 1'b0);
		wait_hi(0, PWRUP + 4);
		chk(backup_supply_pin_out, 1'b1);
		chk(backup_supply_pin_oe_n_out, 1'b0);
		chk(cal_active_out, 1'b1);
		for (i = 0; i < 4; i++)
		begin
			wd[i] = 8'($random(seed));
			acc(1'b1, 1'b0, adr[i], wd[i]);
		end
		acc(1'b1, 1'b0, 9'h0E0, 8'h5A);
		for (i = 0; i < 4; i++)
			acc(1'b0, 1'b1, adr[i], wd[i]);
		for (i = 0; i < 8; i++)
			acc(1'b0, 1'b1, 9'(9'h0E0 + i), gpm_pkg::ID_CODE[8 * i +: 8]);
		acc(1'b0, 1'b1, 9'h108, 8'h00);
		acc(1'b0, 1'b0, 9'h000, 8'h00);
		// converter pulses inside the calibration window feed the offset
		np = ($random(seed) & 7) + 1;
		nn = ($random(seed) & 7) + 1;
		pulses(np, nn);
		chk(32'(offset_count_out), {16'h0000, 16'(np - nn)});
		chk(charge_count_out, 32'h00000000);
		chk(discharge_count_out, 32'h00000000);
		stat_drive_in <= 1'b1;
		bus_pull_req_in <= 1'b1;
		repeat (3) @(posedge clk_in);
		chk(stat_oe_n_out, 1'b0);
		chk(bus_line_oe_n_out, 1'b0);
		pack_present_in <= 1'b0;
		wait_hi(1, SLP + 4);
		chk(stat_oe_n_out, 1'b1);
		chk(bus_line_oe_n_out, 1'b1);
		chk(ready_out, 1'b0);
		bus_pull_req_in <= 1'b0;
		repeat (SLP) @(posedge clk_in);
		chk(asleep_out, 1'b1);
		wake_req <= 1'b1;
		@(posedge clk_in);
		wake_req <= 1'b0;
		wait_hi(0, WAKE + 12);
		repeat (SLP + 4) @(posedge clk_in);
		chk(asleep_out, 1'b0);
		chk(stat_oe_n_out, 1'b0);
		other_pull <= 1'b1;
		repeat (3) @(posedge clk_in);
		other_pull <= 1'b0;
		repeat (3) @(posedge clk_in);
		chk(ready_out, 1'b1);
		supply_valid_in <= 1'b0;
		repeat (3) @(posedge clk_in);
		chk(backup_supply_pin_oe_n_out, 1'b1);
		// once the window closes the offset is removed and pulses count as charge or discharge
		wait_hi(2, 42000);
		chk(offset_count_out, 32'h00000000);
		np = ($random(seed) & 7) + 1;
		nn = ($random(seed) & 7) + 1;
		pulses(np, nn);
		chk(charge_count_out, 32'(np));
		chk(discharge_count_out, 32'(nn));
		summarize();
	end
endmodule
